// File: core/fss_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
// three-stage pin synchroniser; level moves only when stages two and three agree
module fss_pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pin and filtered level
  input wire logic pinIn,
  output logic level
);

  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } fss_sync_s;

  fss_sync_s state_reg;
  fss_sync_s state_next;

  always_comb begin
    state_next = state_reg;
    state_next.stage = {state_reg.stage[1:0], pinIn};
    // only the second and third stages vote, the first may still be settling
    if (state_reg.stage[1] == state_reg.stage[2]) begin
      state_next.level = state_reg.stage[2];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{stage: {3{RESET_LEVEL}}, level: RESET_LEVEL};
    end else begin
      state_reg <= state_next;
    end
  end

  assign level = state_reg.level;

endmodule
`default_nettype wire

// File: core/fss_pkg.sv
package fss_pkg;

  // serial command codes
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_READ_ANY_REG = 8'h65;
  localparam logic [7:0] CMD_WRITE_ANY_REG = 8'h71;

  // frame field lengths in bits
  localparam int CMD_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int DATA_BITS = 8;
  localparam logic [4:0] CMD_LAST = 5'(CMD_BITS - 1);
  localparam logic [4:0] ADDR_LAST = 5'(ADDR_BITS - 1);
  localparam logic [4:0] DATA_LAST = 5'(DATA_BITS - 1);
  localparam logic [2:0] OUT_LAST = 3'(DATA_BITS - 1);

  // register addresses inside the any-register space
  localparam logic [23:0] ADDR_ERASE_SUSPEND_STATUS = 24'h000001;
  localparam logic [23:0] ADDR_NV_PROTECTION_CONFIG = 24'h000002;

  // erase_suspend_status layout
  localparam int ST2_ERASE_RESULT = 2;
  localparam int ST2_ERASE_PAUSED = 1;
  localparam int ST2_PROGRAM_PAUSED = 0;
  localparam logic [7:0] ST2_RESET = 8'h00;

  // nonvolatile_protection_config layout
  localparam int CFG_PROTECT_START = 5;
  localparam int CFG_PROTECT_VOLATILITY = 3;
  localparam int CFG_PARAM_PLACE = 2;
  localparam int CFG_QUAD_DEFAULT = 1;
  localparam int CFG_FREEZE_DEFAULT = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic CFG_FREEZE_DEFAULT_VAL = 1'b0;

  // read-password boot window
  localparam int BOOT_RANGE_KB = 256;
  localparam int BOOT_RANGE_BYTES = BOOT_RANGE_KB * 1024;
  localparam int BOOT_RANGE_SHIFT = $clog2(BOOT_RANGE_BYTES);
  localparam int ARRAY_ADDR_BITS = 27;

  // pin levels at reset
  localparam logic SCK_IDLE = 1'b0;
  localparam logic SEL_IDLE_N = 1'b1;
  localparam logic DATA_IDLE = 1'b0;

  typedef enum logic [2:0] {
    PH_CMD,
    PH_ADDR,
    PH_WRITE_DATA,
    PH_READ_DATA,
    PH_HOLD,
    PH_IGNORE
  } fss_phase_e;

endpackage

// File: core/fss_status_config_regs.sv
// Summary of operation
// R1: second status bits are volatile, read-only, defaults set by hardware.
// R2: status bits 7 to 3 read zero.
// R3: status bit 2 holds last erase result of sector named by erase-status command.
// R4: host issues erase-status command right before reading the status register.
// R5: erase result is not valid while program or erase is suspended.
// R6: status bit 1 reads 1 in erase-suspend, host cannot write it.
// R7: status bit 0 reads 1 in program-suspend, host cannot write it.
// R8: read-any-register returns both registers; writes only via write-any-register.
// R9: config writable bits change through write-any-register.
// R10: config bit 5 sets protection start: 0 top, 1 bottom; reset cleared.
// R11: one-time bits once 1 ignore a written 0 without error.
// R12: host sets protection start before any array program or erase.
// R13: read-password mode allows only 256 KB boot range reads after reset.
// R14: config bit 3 one-time: 1 volatile protect bits, 0 non-volatile.
// R15: config bit 2 places 4 KB sectors high or low; reserved if uniform.
// R16: config bit 1 is writable default of volatile quad width bit.
// R17: config bit 0 is read-only freeze default, zero.
// R18: config bits 7, 6 and 4 read zero.
// R19: register writes need write-enable latch set by write-enable command.
`timescale 1ns/1ns
`default_nettype none
module fss_status_config_regs #(
  parameter int ARRAY_ADDR_W = fss_pkg::ARRAY_ADDR_BITS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial link pins
  input wire logic sck,
  input wire logic selN,
  input wire logic sdIn,
  output logic sdOut,
  output logic sdOutOeN,
  // suspend and erase-status engines
  input wire logic eraseSuspendActive,
  input wire logic programSuspendActive,
  input wire logic eraseStatusUpdate,
  input wire logic eraseStatusDone,
  input wire logic uniformSectors,
  // read-password boot window check
  input wire logic readPasswordMode,
  input wire logic [ARRAY_ADDR_W-1:0] readAddr,
  output logic readAllowed,
  // configuration to the rest of the device
  output logic protectStartSelect,
  output logic protectBitsVolatility,
  output logic paramSectorPlace,
  output logic quadWidthDefault,
  output logic freezeDefault,
  output logic writeEnableLatch,
  output logic eraseResultBit
);

  typedef struct packed {
    fss_pkg::fss_phase_e phase;
    logic [4:0] bitCnt;
    logic [2:0] outCnt;
    logic [7:0] shiftIn;
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [7:0] shiftOut;
    logic [7:0] writeData;
    logic sckPrev;
    logic selPrevN;
    logic sdOut;
    logic sdOutOeN;
    logic write_enable_latch;
    logic protectStart;
    logic protectVolatility;
    logic paramPlace;
    logic quadDefault;
    logic eraseResult;
    logic erasePaused;
    logic programPaused;
    logic readAllowed;
  } fss_state_s;

  localparam int BOOT_HI_W = ARRAY_ADDR_W - fss_pkg::BOOT_RANGE_SHIFT;

  logic sckLvl;
  logic selLvlN;
  logic sdInLvl;
  fss_state_s state_reg;
  fss_state_s state_next;

  fss_pin_sync #(.RESET_LEVEL(fss_pkg::SCK_IDLE)) u_sync_sck (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(sck),
    .level(sckLvl)
  );

  fss_pin_sync #(.RESET_LEVEL(fss_pkg::SEL_IDLE_N)) u_sync_sel (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(selN),
    .level(selLvlN)
  );

  fss_pin_sync #(.RESET_LEVEL(fss_pkg::DATA_IDLE)) u_sync_sd (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(sdIn),
    .level(sdInLvl)
  );

  // live register images, sampled at every byte boundary of a read
  function automatic logic [7:0] status2Image(input fss_state_s s);
    logic [7:0] v;
    v = fss_pkg::ST2_RESET; // [R2]
    // suspended: erase result is meaningless, so it reads as not completed
    v[fss_pkg::ST2_ERASE_RESULT] = s.eraseResult & ~(s.erasePaused | s.programPaused); // [R5]
    v[fss_pkg::ST2_ERASE_PAUSED] = s.erasePaused; // [R6]
    v[fss_pkg::ST2_PROGRAM_PAUSED] = s.programPaused; // [R7]
    return v;
  endfunction

  function automatic logic [7:0] config1Image(input fss_state_s s, input logic uniform);
    logic [7:0] v;
    v = fss_pkg::CFG_RESET; // [R18]
    v[fss_pkg::CFG_PROTECT_START] = s.protectStart;
    v[fss_pkg::CFG_PROTECT_VOLATILITY] = s.protectVolatility;
    v[fss_pkg::CFG_PARAM_PLACE] = s.paramPlace & ~uniform; // [R15]
    v[fss_pkg::CFG_QUAD_DEFAULT] = s.quadDefault;
    v[fss_pkg::CFG_FREEZE_DEFAULT] = fss_pkg::CFG_FREEZE_DEFAULT_VAL; // [R17]
    return v;
  endfunction

  function automatic logic [7:0] readImage(input fss_state_s s, input logic uniform);
    logic [7:0] v;
    v = 8'h00;
    if (s.addr == fss_pkg::ADDR_ERASE_SUSPEND_STATUS) begin
      v = status2Image(s); // [R8]
    end else if (s.addr == fss_pkg::ADDR_NV_PROTECTION_CONFIG) begin
      v = config1Image(s, uniform); // [R8]
    end
    return v;
  endfunction

  always_comb begin
    logic sckRise;
    logic sckFall;
    logic selRise;
    logic selFall;
    logic [7:0] byteIn;
    logic [7:0] image;
    logic [BOOT_HI_W-1:0] hiBits;
    sckRise = sckLvl & ~state_reg.sckPrev;
    sckFall = ~sckLvl & state_reg.sckPrev;
    selRise = selLvlN & ~state_reg.selPrevN;
    selFall = ~selLvlN & state_reg.selPrevN;
    byteIn = {state_reg.shiftIn[6:0], sdInLvl};
    image = readImage(state_reg, uniformSectors);
    hiBits = readAddr[ARRAY_ADDR_W-1:fss_pkg::BOOT_RANGE_SHIFT];
    state_next = state_reg;
    state_next.sckPrev = sckLvl;
    state_next.selPrevN = selLvlN;

    // suspend flags follow the engines, nothing on the link can write them
    state_next.erasePaused = eraseSuspendActive; // [R1] [R6]
    state_next.programPaused = programSuspendActive; // [R1] [R7]
    if (eraseStatusUpdate) begin
      state_next.eraseResult = eraseStatusDone; // [R3]
    end

    // bottom window when start select is 0, top window when it is 1
    if (!readPasswordMode) begin
      state_next.readAllowed = 1'b1;
    end else if (state_reg.protectStart) begin
      state_next.readAllowed = &hiBits; // [R13]
    end else begin
      state_next.readAllowed = ~|hiBits; // [R13]
    end

    if (selLvlN) begin
      state_next.sdOutOeN = 1'b1;
      if (selRise && state_reg.phase == fss_pkg::PH_HOLD) begin
        // commands act only on a frame closed at its exact length
        case (state_reg.cmd)
          fss_pkg::CMD_WRITE_ENABLE: begin
            state_next.write_enable_latch = 1'b1; // [R19]
          end
          fss_pkg::CMD_WRITE_DISABLE: begin
            state_next.write_enable_latch = 1'b0;
          end
          fss_pkg::CMD_WRITE_ANY_REG: begin
            if (state_reg.write_enable_latch &&
                state_reg.addr == fss_pkg::ADDR_NV_PROTECTION_CONFIG) begin // [R19] [R8]
              // one-time bits only ever gain ones, a zero is dropped silently
              state_next.protectStart = state_reg.protectStart |
                state_reg.writeData[fss_pkg::CFG_PROTECT_START]; // [R10] [R11] [R9]
              state_next.protectVolatility = state_reg.protectVolatility |
                state_reg.writeData[fss_pkg::CFG_PROTECT_VOLATILITY]; // [R14] [R11]
              if (!uniformSectors) begin
                state_next.paramPlace = state_reg.paramPlace |
                  state_reg.writeData[fss_pkg::CFG_PARAM_PLACE]; // [R15] [R11]
              end
              state_next.quadDefault =
                state_reg.writeData[fss_pkg::CFG_QUAD_DEFAULT]; // [R16] [R9]
            end
            // any write-any-register frame with the latch set clears it, whatever the address; with the latch clear it stays clear
            if (state_reg.write_enable_latch) begin
              state_next.write_enable_latch = 1'b0; // [R19]
            end
          end
          default: begin
          end
        endcase
      end
      state_next.phase = fss_pkg::PH_CMD;
      state_next.bitCnt = 5'h00;
      state_next.outCnt = 3'h0;
    end else if (selFall) begin
      state_next.phase = fss_pkg::PH_CMD;
      state_next.bitCnt = 5'h00;
      state_next.outCnt = 3'h0;
    end else if (sckRise) begin
      state_next.shiftIn = byteIn;
      state_next.bitCnt = state_reg.bitCnt + 5'h01;
      case (state_reg.phase)
        fss_pkg::PH_CMD: begin
          if (state_reg.bitCnt == fss_pkg::CMD_LAST) begin
            state_next.cmd = byteIn;
            state_next.bitCnt = 5'h00;
            case (byteIn)
              fss_pkg::CMD_READ_ANY_REG,
              fss_pkg::CMD_WRITE_ANY_REG: begin
                state_next.phase = fss_pkg::PH_ADDR; // [R8]
              end
              fss_pkg::CMD_WRITE_ENABLE,
              fss_pkg::CMD_WRITE_DISABLE: begin
                state_next.phase = fss_pkg::PH_HOLD;
              end
              default: begin
                state_next.phase = fss_pkg::PH_IGNORE;
              end
            endcase
          end
        end
        fss_pkg::PH_ADDR: begin
          state_next.addr = {state_reg.addr[22:0], sdInLvl};
          if (state_reg.bitCnt == fss_pkg::ADDR_LAST) begin
            state_next.bitCnt = 5'h00;
            state_next.outCnt = 3'h0;
            if (state_reg.cmd == fss_pkg::CMD_READ_ANY_REG) begin
              state_next.phase = fss_pkg::PH_READ_DATA;
            end else begin
              state_next.phase = fss_pkg::PH_WRITE_DATA;
            end
          end
        end
        fss_pkg::PH_WRITE_DATA: begin
          if (state_reg.bitCnt == fss_pkg::DATA_LAST) begin
            state_next.writeData = byteIn;
            state_next.bitCnt = 5'h00;
            state_next.phase = fss_pkg::PH_HOLD;
          end
        end
        fss_pkg::PH_READ_DATA: begin
          state_next.bitCnt = 5'h00;
        end
        fss_pkg::PH_HOLD: begin
          // clocks past the frame's end void the command
          state_next.phase = fss_pkg::PH_IGNORE;
        end
        default: begin
          state_next.bitCnt = 5'h00;
        end
      endcase
    end else if (sckFall && state_reg.phase == fss_pkg::PH_READ_DATA) begin
      // read repeats the same register, refreshed at each byte start
      state_next.sdOutOeN = 1'b0;
      state_next.outCnt = state_reg.outCnt + 3'h1;
      if (state_reg.outCnt == 3'h0) begin
        state_next.sdOut = image[7]; // [R8]
        state_next.shiftOut = {image[6:0], 1'b0};
      end else begin
        state_next.sdOut = state_reg.shiftOut[7];
        state_next.shiftOut = {state_reg.shiftOut[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{
        phase: fss_pkg::PH_CMD,
        bitCnt: 5'h00,
        outCnt: 3'h0,
        shiftIn: 8'h00,
        cmd: 8'h00,
        addr: 24'h000000,
        shiftOut: 8'h00,
        writeData: 8'h00,
        sckPrev: fss_pkg::SCK_IDLE,
        selPrevN: fss_pkg::SEL_IDLE_N,
        sdOut: 1'b0,
        sdOutOeN: 1'b1,
        write_enable_latch: 1'b0,
        protectStart: fss_pkg::CFG_RESET[fss_pkg::CFG_PROTECT_START],
        protectVolatility: fss_pkg::CFG_RESET[fss_pkg::CFG_PROTECT_VOLATILITY],
        paramPlace: fss_pkg::CFG_RESET[fss_pkg::CFG_PARAM_PLACE],
        quadDefault: fss_pkg::CFG_RESET[fss_pkg::CFG_QUAD_DEFAULT],
        eraseResult: fss_pkg::ST2_RESET[fss_pkg::ST2_ERASE_RESULT],
        erasePaused: fss_pkg::ST2_RESET[fss_pkg::ST2_ERASE_PAUSED],
        programPaused: fss_pkg::ST2_RESET[fss_pkg::ST2_PROGRAM_PAUSED],
        readAllowed: 1'b1
      };
    end else begin
      state_reg <= state_next;
    end
  end

  assign sdOut = state_reg.sdOut;
  assign sdOutOeN = state_reg.sdOutOeN;
  assign readAllowed = state_reg.readAllowed;
  assign protectStartSelect = state_reg.protectStart; // [R10]
  assign protectBitsVolatility = state_reg.protectVolatility; // [R14]
  assign paramSectorPlace = state_reg.paramPlace & ~uniformSectors; // [R15]
  assign quadWidthDefault = state_reg.quadDefault; // [R16]
  assign freezeDefault = fss_pkg::CFG_FREEZE_DEFAULT_VAL; // [R17]
  assign writeEnableLatch = state_reg.write_enable_latch;
  assign eraseResultBit = state_reg.eraseResult;

endmodule
`default_nettype wire

// File: testbench/fss_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module fss_host_model (
  // link pins
  output logic sck,
  output logic selN,
  output logic sdIn,
  input wire logic sdOut
);
  // select setup and idle time, stretched for a slow host
  int gap = 320;
  initial begin
    sck = 1'h0;
    selN = 1'h1;
    sdIn = 1'h0;
  end
  task automatic sendByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sdIn = b[i];
      #160 sck = 1'h1;
      #160 sck = 1'h0;
    end
  endtask
  // sample late in the high phase, the device updates after each fall
  task automatic getByte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #160 sck = 1'h1;
      #150 b[i] = sdOut;
      #10 sck = 1'h0;
    end
  endtask
  task automatic frame(input logic [7:0] cmd, input logic [23:0] a, input logic [7:0] wd,
                       output logic [7:0] rd);
    rd = 8'h00;
    selN = 1'h0;
    #(gap);
    sendByte(cmd);
    if (cmd == fss_pkg::CMD_READ_ANY_REG || cmd == fss_pkg::CMD_WRITE_ANY_REG) begin
      sendByte(a[23:16]);
      sendByte(a[15:8]);
      sendByte(a[7:0]);
    end
    if (cmd == fss_pkg::CMD_WRITE_ANY_REG) sendByte(wd);
    if (cmd == fss_pkg::CMD_READ_ANY_REG) getByte(rd);
    #160 selN = 1'h1;
    // released data line must not keep its last level
    sdIn = ~sdIn;
    #(gap);
  endtask
endmodule
`default_nettype wire

// File: testbench/fss_status_config_regs_props.sv
`timescale 1ns/1ns
`default_nettype none
module fss_status_config_regs_props #(
  parameter int ARRAY_ADDR_W = fss_pkg::ARRAY_ADDR_BITS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // link and engine inputs
  input wire logic selN,
  input wire logic sdOutOeN,
  input wire logic eraseStatusUpdate,
  input wire logic eraseStatusDone,
  input wire logic uniformSectors,
  input wire logic readPasswordMode,
  input wire logic [ARRAY_ADDR_W-1:0] readAddr,
  // outputs under watch
  input wire logic readAllowed,
  input wire logic protectStartSelect,
  input wire logic protectBitsVolatility,
  input wire logic paramSectorPlace,
  input wire logic quadWidthDefault,
  input wire logic freezeDefault,
  input wire logic writeEnableLatch,
  input wire logic eraseResultBit
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // bits above the 256 KB boot range
  localparam int HI_W = ARRAY_ADDR_W - fss_pkg::BOOT_RANGE_SHIFT;
  logic [HI_W-1:0] bootHi;
  assign bootHi = readAddr[ARRAY_ADDR_W-1:fss_pkg::BOOT_RANGE_SHIFT];
  property p_freeze; freezeDefault == 1'h0; endproperty
  a_freeze: assert property (p_freeze) else $error("freeze default set");
  property p_otp; !$fell(protectStartSelect) && !$fell(protectBitsVolatility); endproperty
  a_otp: assert property (p_otp) else $error("one-time bit cleared");
  property p_cfg_latch;
    !$stable({protectStartSelect, protectBitsVolatility, quadWidthDefault})
      |-> $past(writeEnableLatch);
  endproperty
  a_cfg_latch: assert property (p_cfg_latch) else $error("config changed unlatched");
  property p_uniform; uniformSectors |-> !paramSectorPlace; endproperty
  a_uniform: assert property (p_uniform) else $error("placement not reserved");
  property p_latch_end; $rose(writeEnableLatch) |-> selN && $past(selN, 2); endproperty
  a_latch_end: assert property (p_latch_end) else $error("latch set inside frame");
  property p_erase_cap; eraseStatusUpdate |=> eraseResultBit == $past(eraseStatusDone); endproperty
  a_erase_cap: assert property (p_erase_cap) else $error("erase result not taken");
  property p_erase_hold; !$stable(eraseResultBit) |-> $past(eraseStatusUpdate); endproperty
  a_erase_hold: assert property (p_erase_hold) else $error("erase result moved");
  property p_oe_sel; !sdOutOeN |-> !$past(selN, 6); endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("output enabled unselected");
  property p_open; !readPasswordMode |=> readAllowed; endproperty
  a_open: assert property (p_open) else $error("read blocked outside mode");
  property p_boot;
    readPasswordMode |=> readAllowed ==
      ($past(protectStartSelect) ? &$past(bootHi) : $past(bootHi) == '0);
  endproperty
  a_boot: assert property (p_boot) else $error("boot range wrong");
  c_boot: cover property (readPasswordMode && protectStartSelect ##1 readAllowed);
  c_latch: cover property ($rose(writeEnableLatch));
  c_read: cover property ($fell(sdOutOeN));
  c_erase: cover property (eraseStatusUpdate && eraseStatusDone);
endmodule
bind fss_status_config_regs fss_status_config_regs_props #(.ARRAY_ADDR_W(ARRAY_ADDR_W)) i_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .selN(selN), .sdOutOeN(sdOutOeN),
  .eraseStatusUpdate(eraseStatusUpdate), .eraseStatusDone(eraseStatusDone),
  .uniformSectors(uniformSectors), .readPasswordMode(readPasswordMode),
  .readAddr(readAddr), .readAllowed(readAllowed), .protectStartSelect(protectStartSelect),
  .protectBitsVolatility(protectBitsVolatility), .paramSectorPlace(paramSectorPlace),
  .quadWidthDefault(quadWidthDefault), .freezeDefault(freezeDefault),
  .writeEnableLatch(writeEnableLatch), .eraseResultBit(eraseResultBit)
);
`default_nettype wire

// File: testbench/fss_status_config_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module fss_status_config_regs_tb;
  logic clk_sys, rst_n, sck, selN, sdIn, sdOut, sdOutOeN, eSus, pSus, esUpd, esDone, uni, pwMode;
  logic readAllowed, protStart, protVol, paramPlace, quadDef, frzDef, write_enable_latch, eraseRes, res;
  logic [26:0] readAddr;
  logic [7:0] cfgNv, rd, wv;
  int mismatches, cmp_count;
  localparam logic [23:0] AST = fss_pkg::ADDR_ERASE_SUSPEND_STATUS;
  localparam logic [23:0] ACF = fss_pkg::ADDR_NV_PROTECTION_CONFIG;
  fss_host_model i_fss_host_model (.sck(sck), .selN(selN), .sdIn(sdIn), .sdOut(sdOut));
  fss_status_config_regs #(.ARRAY_ADDR_W(27)) i_fss_status_config_regs (
    .clk_sys(clk_sys), .rst_n(rst_n), .sck(sck), .selN(selN), .sdIn(sdIn), .sdOut(sdOut),
    .sdOutOeN(sdOutOeN), .eraseSuspendActive(eSus), .programSuspendActive(pSus),
    .eraseStatusUpdate(esUpd), .eraseStatusDone(esDone), .uniformSectors(uni),
    .readPasswordMode(pwMode), .readAddr(readAddr), .readAllowed(readAllowed),
    .protectStartSelect(protStart), .protectBitsVolatility(protVol),
    .paramSectorPlace(paramPlace), .quadWidthDefault(quadDef), .freezeDefault(frzDef),
    .writeEnableLatch(write_enable_latch), .eraseResultBit(eraseRes));
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] stImg(logic e, logic p, logic r);
    return {5'h00, r & ~(e | p), e, p};
  endfunction
  function automatic logic [7:0] cfgImg(logic [7:0] nv, logic u);
    return {2'h0, nv[5], 1'h0, nv[3], nv[2] & ~u, nv[1], 1'h0};
  endfunction
  function automatic logic allowExp(logic m, logic top, logic [26:0] a);
    return !m || (top ? &a[26:18] : a[26:18] == 9'h000);
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [23:0] a, input logic [7:0] d);
    i_fss_host_model.frame(c, a, d, rd);
  endtask
  task automatic wrReg(input logic [23:0] a, input logic [7:0] v, input logic en);
    if (en) cmd(fss_pkg::CMD_WRITE_ENABLE, 24'h000000, 8'h00);
    cmd(fss_pkg::CMD_WRITE_ANY_REG, a, v);
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  task automatic winTest();
    for (int i = 0; i < 12; i++) begin
      @(negedge clk_sys);
      pwMode = 1'($urandom);
      readAddr = (i % 3 == 0) ? {9'h000, 18'($urandom)} :
                 (i % 3 == 1) ? {9'h1FF, 18'($urandom)} : 27'($urandom);
      @(negedge clk_sys);
      chk1(readAllowed, allowExp(pwMode, cfgNv[5], readAddr), "boot");
    end
    pwMode = 1'h0;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    mismatches++;
    $display("ERROR %0t timeout", $time);
    print_verdict();
  end
  initial begin
    {rst_n, eSus, pSus, esUpd, esDone, uni, pwMode, res} = 8'h00;
    readAddr = 27'h0000000;
    cfgNv = 8'h00;
    void'($urandom(32'hF720A1E6));
    repeat (6) @(negedge clk_sys);
    rst_n = 1'h1;
    repeat (4) @(negedge clk_sys);
    cmd(fss_pkg::CMD_READ_ANY_REG, AST, 8'h00);
    chk8(rd, 8'h00, "status reset");
    chk1(sdOutOeN, 1'h1, "oe released");
    cmd(fss_pkg::CMD_READ_ANY_REG, ACF, 8'h00);
    chk8(rd, 8'h00, "config reset");
    chk1(frzDef, 1'h0, "freeze");
    winTest();
    done("reset");
    for (int k = 0; k < 8; k++) begin
      @(negedge clk_sys);
      {eSus, pSus} = 2'(k);
      esDone = 1'($urandom);
      res = esDone;
      esUpd = 1'h1;
      @(negedge clk_sys);
      esUpd = 1'h0;
      // erase-status pulse right before the read
      cmd(fss_pkg::CMD_READ_ANY_REG, AST, 8'h00);
      chk8(rd, stImg(eSus, pSus, res), "status");
      chk1(eraseRes, res, "erase result");
    end
    {eSus, pSus} = 2'h0;
    wrReg(AST, 8'hFF, 1'h1);
    cmd(fss_pkg::CMD_READ_ANY_REG, AST, 8'h00);
    chk8(rd, stImg(1'h0, 1'h0, res), "status write");
    done("status");
    wrReg(ACF, 8'h2E, 1'h0);
    cmd(fss_pkg::CMD_WRITE_ENABLE, 24'h000000, 8'h00);
    chk1(write_enable_latch, 1'h1, "latch set");
    cmd(fss_pkg::CMD_WRITE_DISABLE, 24'h000000, 8'h00);
    chk1(write_enable_latch, 1'h0, "latch dropped");
    wrReg(ACF, 8'h2E, 1'h0);
    cmd(8'h9F, 24'h000000, 8'h00);
    cmd(fss_pkg::CMD_READ_ANY_REG, ACF, 8'h00);
    chk8(rd, 8'h00, "refused");
    cmd(fss_pkg::CMD_READ_ANY_REG, 24'h000007, 8'h00);
    chk8(rd, 8'h00, "unmapped");
    done("refused");
    // protect start settled before any array work
    for (int k = 0; k < 7; k++) begin
      wv = (k == 0) ? 8'h02 : (k == 5) ? 8'hFF : (k == 6) ? 8'h00 : 8'($urandom);
      @(negedge clk_sys);
      uni = (k == 3);
      wrReg(ACF, wv, 1'h1);
      cfgNv = {2'h0, cfgNv[5] | wv[5], 1'h0, cfgNv[3] | wv[3],
               cfgNv[2] | (wv[2] & ~uni), wv[1], 1'h0};
      cmd(fss_pkg::CMD_READ_ANY_REG, ACF, 8'h00);
      chk8(rd, cfgImg(cfgNv, uni), "config");
      chk8({4'h0, protStart, protVol, paramPlace, quadDef},
           {4'h0, cfgNv[5], cfgNv[3], cfgNv[2] & ~uni, cfgNv[1]}, "config pins");
      chk1(write_enable_latch, 1'h0, "latch after write");
    end
    winTest();
    done("config");
    @(negedge clk_sys);
    rst_n = 1'h0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'h1;
    // synchronisers need a few clocks before a frame may open
    repeat (4) @(negedge clk_sys);
    i_fss_host_model.gap = 2000;
    cmd(fss_pkg::CMD_READ_ANY_REG, ACF, 8'h00);
    chk8(rd, 8'h00, "config after reset");
    i_fss_host_model.gap = 320;
    done("rereset");
    print_verdict();
  end
endmodule
`default_nettype wire
